// File: bench/usb_ep_ctrl_bench.sv
// self-checking bench for the endpoint control block
// assumes the checker is bound from its own file
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module usb_ep_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 pclk = 0, presetn = 0, go = 0;
   logic                 psel = 0, penable = 0, pwrite = 0;
   logic [11:0]          paddr = '0;
   logic [31:0]          pwdata = '0, prdata, rd;
   logic                 pready, pslverr, err;
   logic [2:0]           ep = '0;
   logic [6:0]           endpoint_irq;
   usb_ep_pkg::usb_evt_s evt = '0;
   usb_ep_pkg::usb_evt_s usb_evt [usb_ep_pkg::NUM_EP];
   usb_ep_pkg::usb_ctl_s usb_ctl [usb_ep_pkg::NUM_EP];
   int                   error_cnt = 0, num_checks = 0, commits = 0, kills = 0;
   int                   releases = 0;
   // ------------------------------------------
   // clock, parts, pulse counters
   // ------------------------------------------
   always #2 pclk = ~pclk;
   usb_ep_ctrl dut_u (.pclk(pclk), .presetn(presetn), .ce(1'h1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .usb_evt(usb_evt), .usb_ctl(usb_ctl), .endpoint_irq(endpoint_irq));
   usb_host_model host_u (.pclk(pclk), .presetn(presetn), .go(go),
      .ep(ep), .evt(evt), .usb_evt(usb_evt));
   always @(posedge pclk) begin
      commits += usb_ctl[2].bank_commit;
      kills += usb_ctl[2].kill_bank;
      releases += usb_ctl[1].bank_release;
   end
   // apb master: waits on pready, never on a cycle count
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // only the watchdog ends a wait that never sees pready
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // one host event on one endpoint
   task automatic ev(input logic [2:0] e, input logic [9:0] v);
      @(posedge pclk);
      go <= 1; ep <= e; evt <= v;
      @(posedge pclk);
      go <= 0;
   endtask
   task automatic t_reset;
      for (int i = 0; i < 7; i++) begin
         apb(0, 12'h1c0 + 12'(4 * i), '0);
         `CHK(rd, 32'h0000_0000)
      end
      apb(0, 12'h13c, '0);
      `CHK(rd[9:8], 2'h1)
      apb(1, 12'h1c0, '1);
      `CHK(err, 1'h1)
      apb(0, 12'hffc, '0);
      `CHK(err, 1'h1)
      $display("reset test done");
   endtask
   task automatic t_enables;
      apb(1, 12'h104, 32'h6); // ep1 out, one bank
      apb(1, 12'h1f4, 32'h000d_10ff);
      apb(0, 12'h1c4, '0);
      `CHK(rd, 32'h0009_10ff)
      apb(1, 12'h224, 32'h0008_000f);
      apb(0, 12'h1c4, '0);
      `CHK(rd, 32'h0001_10f0)
      $display("enable test done");
   endtask
   task automatic t_force;
      apb(1, 12'h194, 32'hf8);
      apb(0, 12'h194, '0);
      `CHK(rd, 32'h0)
      apb(0, 12'h134, '0);
      `CHK(rd[7:0], 8'hf8)
      `CHK(endpoint_irq[1], 1'h1)
      `CHK(usb_ctl[1].dma_pause_now, 1'h1)
      apb(1, 12'h164, 32'hff);
      apb(0, 12'h134, '0);
      `CHK(endpoint_irq[1], 1'h0)
      `CHK(usb_ctl[1].dma_hold_new, 1'h0)
      for (int k = 1; k >= 0; k--) begin
         apb(1, 12'h194, 32'h1000);
         apb(0, 12'h134, '0);
         `CHK(rd[12], 1'(k))
      end
      $display("force test done");
   endtask
   task automatic t_stall;
      apb(1, 12'h1f0, 32'h0008_0000);
      apb(0, 12'h1c0, '0);
      `CHK(rd[19], 1'h1)
      ev(0, 10'h004);
      ev(0, 10'h002);
      apb(0, 12'h1c0, '0);
      `CHK(rd, 32'h0)
      apb(0, 12'h130, '0);
      `CHK(rd[13], 1'h0)
      $display("stall test done");
   endtask
   task automatic t_bank;
      apb(1, 12'h108, 32'h5); // ep2 in, one bank
      ev(2, 10'h001);
      apb(0, 12'h1c8, '0);
      `CHK(rd[14], 1'h1)
      apb(1, 12'h228, 32'h4000);
      apb(0, 12'h138, '0);
      `CHK(rd[11:10], 2'h1)
      `CHK(commits, 1)
      apb(1, 12'h1f8, 32'h2000); // single kill, none pending
      apb(0, 12'h1c8, '0);
      `CHK(rd[14:13], 2'h0)
      `CHK(kills, 1)
      apb(0, 12'h138, '0);
      `CHK(rd[11:10], 2'h0)
      $display("bank test done");
   endtask
   // ep1 out, one bank: fill, hand over, release with pause dropped
   task automatic t_out;
      apb(1, 12'h224, 32'h1000); // busy source kept out of the way
      apb(1, 12'h1f4, 32'h2);
      ev(1, 10'h002);
      apb(0, 12'h1c4, '0);
      `CHK(rd[14], 1'h1)
      apb(0, 12'h134, '0);
      `CHK(rd, 32'h0000_7402)
      `CHK(usb_ctl[1].busy_bank_count, 2'h1)
      `CHK(usb_ctl[1].dma_hold_new, 1'h1)
      `CHK(usb_ctl[1].dma_pause_now, 1'h0)
      apb(1, 12'h224, 32'h0001_4000);
      apb(0, 12'h134, '0);
      `CHK(rd, 32'h0000_4002)
      `CHK(releases, 1)
      `CHK(usb_ctl[1].dma_hold_new, 1'h0)
      $display("out test done");
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // main sequence; watchdog far beyond the 140 or so cycles needed
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_enables();
      t_force();
      t_stall();
      t_bank();
      t_out();
      give_verdict();
   end
   initial begin
      #20000;
      error_cnt++;
      give_verdict();
   end
endmodule
`default_nettype wire

// File: bench/usb_ep_ctrl_properties.sv
// port assertions for the endpoint control block
// assumes ep0 stays a control endpoint and ce is held high
`default_nettype none
module usb_ep_ctrl_properties (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 ce,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire usb_ep_pkg::usb_evt_s usb_evt [usb_ep_pkg::NUM_EP],
   input wire usb_ep_pkg::usb_ctl_s usb_ctl [usb_ep_pkg::NUM_EP]
);
   // ------------------------------------------
   // decode of the request seen on the bus
   // ------------------------------------------
   wire setup = psel && !penable && ce;
   wire ctrl_win = paddr inside {[12'h1c0:12'h1d8]};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_once:
   assert property (setup |=> pready ##1 !pready) else $error("bad answer");
   chk_ready_idle:
   assert property (!psel |=> !pready) else $error("answer without request");
   chk_ctrl_werr:
   assert property (setup && pwrite && ctrl_win |=> pslverr)
      else $error("write to control copy accepted");
   chk_ctrl_zero:
   assert property (setup && !pwrite && ctrl_win |=> prdata[31:20] == 0
      && !prdata[18] && !prdata[17] && !prdata[15] && prdata[11:8] == 0)
      else $error("unused control bits not zero");
   chk_ep0_handover:
   assert property (setup && !pwrite && paddr == 12'h1c0 |=> !prdata[14])
      else $error("handover seen on control endpoint");
   chk_toggle_pulse:
   assert property (usb_ctl[1].toggle_reset |=> !usb_ctl[1].toggle_reset)
      else $error("toggle reset not self clearing");
   chk_setup_stall:
   assert property (usb_evt[0].setup_underflow |-> ##[1:3]
      !usb_ctl[0].stall_request) else $error("setup left stall");
   chk_commit_once:
   assert property (usb_ctl[2].bank_commit |=> !usb_ctl[2].bank_commit)
      else $error("commit longer than a pulse");
   chk_pause_hold:
   assert property (usb_ctl[1].dma_pause_now |-> usb_ctl[1].dma_hold_new)
      else $error("pause without hold");
endmodule
bind usb_ep_ctrl usb_ep_ctrl_properties chk_u (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .usb_evt(usb_evt), .usb_ctl(usb_ctl));
`default_nettype wire

// File: bench/usb_host_model.sv
// host side model: turns bench requests into engine event pulses
// assumes the bench raises go for one cycle per event
`default_nettype none
module usb_host_model (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 go,
   input  wire logic [2:0]           ep,
   input  wire usb_ep_pkg::usb_evt_s evt,
   output var  usb_ep_pkg::usb_evt_s usb_evt [usb_ep_pkg::NUM_EP]
);
   // one-cycle pulses; other endpoints see nothing, never a stale event
   always_ff @(posedge pclk or negedge presetn)
      for (int i = 0; i < usb_ep_pkg::NUM_EP; i++)
         if (!presetn) usb_evt[i] <= '0;
         else usb_evt[i] <= (go && ep == 3'(i)) ? evt : '0;
endmodule
`default_nettype wire

// File: hw/ep_bank_tracker.sv
// busy bank counter and kill arbitration for one endpoint
// assumes fill/drain/in_token are single-cycle pulses on pclk

`default_nettype none

module ep_bank_tracker (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ce,
   input  wire logic       is_in,
   input  wire logic [1:0] banks,
   input  wire logic       fill,
   input  wire logic       drain,
   input  wire logic       kill_req,
   input  wire logic       in_token,
   output var  logic [1:0] count_reg,
   output var  logic       kill_done,
   output var  logic       kill_accept
);

   // ----------------------------------------
   // kill arbitration
   // ----------------------------------------
   logic       empty;
   logic       blocked;
   logic [1:0] count_next;

   // lone bank on the wire cannot be taken back
   assign empty       = count_reg == 2'h0;
   assign blocked     = in_token && count_reg == 2'h1;
   // two or more queued: last bank goes even mid-token
   assign kill_accept = kill_req && is_in && !empty && !blocked;
   // finish: bank killed, or nothing left to kill
   assign kill_done   = kill_accept || (kill_req && empty);

   // ----------------------------------------
   // count, saturating at configured banks
   // ----------------------------------------
   always_comb begin
      count_next = count_reg;
      if (fill && !drain && !kill_accept && count_reg != banks) begin
         count_next = count_reg + 2'h1;
      end else if (!fill && (drain || kill_accept) && !empty) begin
         count_next = count_reg - 2'h1;
      end
   end

   // frozen while ce is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 2'h0;
      end else if (ce) begin
         count_reg <= count_next;
      end
   end

endmodule

`default_nettype wire

// File: hw/usb_ep_ctrl.sv
// per-endpoint control bits for seven usb endpoints, apb slave
// assumes packet engine events arrive on pclk, one cycle each
//
// Decided for this implementation: the APB register port.

`default_nettype none

module usb_ep_ctrl (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                ce,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   input  wire usb_ep_pkg::usb_evt_s usb_evt [usb_ep_pkg::NUM_EP],
   output var  usb_ep_pkg::usb_ctl_s usb_ctl [usb_ep_pkg::NUM_EP],
   output var  logic [6:0]          endpoint_irq
);

   // ----------------------------------------
   // address decode helpers
   // ----------------------------------------
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] base);
      return (a >= base) && (a < base + usb_ep_pkg::EP_SPAN)
             && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [2:0] ep_of(input logic [11:0] a,
                                        input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      return d[4:2];
   endfunction

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic        pready_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic        setup;
   logic        wr;
   logic        hit_cfg;
   logic        hit_sta;
   logic        hit_sclr;
   logic        hit_sset;
   logic        hit_ctrl;
   logic        hit_cset;
   logic        hit_cclr;
   logic        hit_any;
   logic [2:0]  ep_sel;
   logic [31:0] rd_next;
   logic        err_next;
   logic [31:0] ctrl_word   [usb_ep_pkg::NUM_EP];
   logic [31:0] status_word [usb_ep_pkg::NUM_EP];
   logic [31:0] cfg_word    [usb_ep_pkg::NUM_EP];

   // writes land only at the access edge that sees pready
   assign setup    = psel & ~penable;
   assign wr       = psel & penable & pready_reg & pwrite;
   assign hit_cfg  = hit(paddr, usb_ep_pkg::OFS_CFG);
   assign hit_sta  = hit(paddr, usb_ep_pkg::OFS_STATUS);
   assign hit_sclr = hit(paddr, usb_ep_pkg::OFS_STA_CLR);
   assign hit_sset = hit(paddr, usb_ep_pkg::OFS_STA_SET);
   assign hit_ctrl = hit(paddr, usb_ep_pkg::OFS_CTRL);
   assign hit_cset = hit(paddr, usb_ep_pkg::OFS_CTRL_SET);
   assign hit_cclr = hit(paddr, usb_ep_pkg::OFS_CTRL_CLR);
   assign hit_any  = hit_cfg | hit_sta | hit_sclr | hit_sset
                   | hit_ctrl | hit_cset | hit_cclr;

   // endpoint index from whichever window was hit
   assign ep_sel =
      hit_cfg  ? ep_of(paddr, usb_ep_pkg::OFS_CFG)      :
      hit_sta  ? ep_of(paddr, usb_ep_pkg::OFS_STATUS)   :
      hit_sclr ? ep_of(paddr, usb_ep_pkg::OFS_STA_CLR)  :
      hit_sset ? ep_of(paddr, usb_ep_pkg::OFS_STA_SET)  :
      hit_ctrl ? ep_of(paddr, usb_ep_pkg::OFS_CTRL)     :
      hit_cset ? ep_of(paddr, usb_ep_pkg::OFS_CTRL_SET) :
      hit_cclr ? ep_of(paddr, usb_ep_pkg::OFS_CTRL_CLR) : 3'h0;

   // write-only windows read as zero
   assign rd_next =
      hit_ctrl ? ctrl_word[ep_sel]   :
      hit_sta  ? status_word[ep_sel] :
      hit_cfg  ? cfg_word[ep_sel]    : 32'h0000_0000;

   // unmapped, or a write to a read-only window
   assign err_next = !hit_any || (pwrite && (hit_ctrl || hit_sta));

   // ----------------------------------------
   // apb answer: one wait-free access after setup
   // ----------------------------------------
   // registering the answer costs nothing: apb has a setup cycle anyway
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (ce) begin
         pready_reg <= setup;
         if (setup) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
            pslverr_reg <= err_next;
         end
      end
   end

   assign pready  = pready_reg;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------
   // endpoint slices
   // ----------------------------------------
   genvar e;
   generate
      for (e = 0; e < usb_ep_pkg::NUM_EP; e = e + 1) begin : g_ep
         logic                  sel;
         logic [31:0]           cset;
         logic [31:0]           cclr;
         logic [31:0]           sset;
         logic [31:0]           sclr;
         logic                  wr_cfg;
         logic [3:0]            cfg_reg;
         logic [7:0]            flags_reg;
         logic [7:0]            en_reg;
         logic                  en_busy_reg;
         logic                  force_busy_reg;
         logic                  handover_reg;
         logic                  kill_reg;
         logic                  pause_reg;
         logic                  stall_reg;
         logic [1:0]            toggle_reg;
         logic                  irq_reg;
         usb_ep_pkg::usb_ctl_s  ctl_reg;
         usb_ep_pkg::ep_type_e  ep_type;
         usb_ep_pkg::usb_evt_s  ev;
         logic                  is_ctl;
         logic                  is_in;
         logic                  is_out;
         logic [1:0]            banks;
         logic [1:0]            count;
         logic [7:0]            evt_flags;
         logic [7:0]            flags_next;
         logic                  busy_src;
         logic                  irq_src;
         logic                  late_src;
         logic                  packet;
         logic                  setup_rx;
         logic                  fill;
         logic                  drain;
         logic                  commit;
         logic                  release_bank;
         logic                  kill_done;
         logic                  kill_accept;

         // one-hot write strobes for this endpoint
         assign sel    = wr && ep_sel == 3'(e);
         assign cset   = {32{sel & hit_cset}} & pwdata;
         assign cclr   = {32{sel & hit_cclr}} & pwdata;
         assign sset   = {32{sel & hit_sset}} & pwdata;
         assign sclr   = {32{sel & hit_sclr}} & pwdata;
         assign wr_cfg = sel & hit_cfg;

         assign ev      = usb_evt[e];
         assign ep_type = usb_ep_pkg::ep_type_e'(cfg_reg[1:0]);
         assign banks   = cfg_reg[3:2];
         assign is_ctl  = ep_type == usb_ep_pkg::EP_CONTROL;
         assign is_in   = ep_type == usb_ep_pkg::EP_IN;
         assign is_out  = ep_type == usb_ep_pkg::EP_OUT;

         // engine events in flag-bit order
         assign evt_flags = {ev.short_packet, ev.crc_stalled,
                             ev.overflow, ev.nak_in, ev.nak_out,
                             ev.setup_underflow, ev.bank_received,
                             ev.bank_sent};
         assign setup_rx  = ev.setup_underflow & is_ctl;
         assign packet    = ev.bank_sent | ev.bank_received;

         // hardware and force set beat a same-cycle clear
         assign flags_next = (flags_reg & ~sclr[7:0]) | evt_flags
                           | sset[7:0];

         // bank handover only on data endpoints
         assign commit       = cclr[usb_ep_pkg::B_HANDOVER]
                             & handover_reg & is_in;
         assign release_bank = cclr[usb_ep_pkg::B_HANDOVER]
                             & handover_reg & is_out;
         assign fill  = is_in ? commit : ev.bank_received & is_out;
         assign drain = is_in ? ev.bank_sent : release_bank;

         ep_bank_tracker u_banks (
            .pclk        (pclk),
            .presetn     (presetn),
            .ce          (ce),
            .is_in       (is_in),
            .banks       (banks),
            .fill        (fill),
            .drain       (drain),
            .kill_req    (kill_reg),
            .in_token    (ev.in_token),
            .count_reg   (count),
            .kill_done   (kill_done),
            .kill_accept (kill_accept)
         );

         // in: all free; out: all busy; or forced for
         assign busy_src = force_busy_reg
                         | (is_in && count == 2'h0)
                         | (is_out && count == banks);
         // any enabled source, ignoring the global enable
         assign irq_src  = |(flags_reg & en_reg)
                         | (busy_src & en_busy_reg);
         // sources not tied to a freshly filled bank
         assign late_src =
            |(flags_reg[7:usb_ep_pkg::NEWBANK_W]
              & en_reg[7:usb_ep_pkg::NEWBANK_W])
            | (busy_src & en_busy_reg);

         // config word is ours; everything else in this slice below
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cfg_reg <= usb_ep_pkg::CFG_RESET;
            end else if (ce && wr_cfg) begin
               cfg_reg <= pwdata[3:0];
            end
         end

         // interrupt flags and enables
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               flags_reg      <= 8'h00;
               en_reg         <= 8'h00;
               en_busy_reg    <= 1'b0;
               force_busy_reg <= 1'b0;
            end else if (ce) begin
               flags_reg <= flags_next;
               en_reg    <= (en_reg | cset[7:0]) & ~cclr[7:0];
               en_busy_reg <= (en_busy_reg | cset[usb_ep_pkg::B_BUSY])
                  & ~cclr[usb_ep_pkg::B_BUSY];
               if (sset[usb_ep_pkg::B_BUSY]) begin
                  force_busy_reg <= ~force_busy_reg;
               end
            end
         end

         // bank handover, kill, stall, pause, toggle
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               handover_reg <= 1'b0;
               kill_reg     <= 1'b0;
               pause_reg    <= 1'b0;
               stall_reg    <= 1'b0;
               toggle_reg   <= usb_ep_pkg::TOGGLE_INIT;
            end else if (ce) begin
               // set with the matching flag beats the clear
               handover_reg <= (handover_reg
                  & ~cclr[usb_ep_pkg::B_HANDOVER])
                  | (is_in & ev.bank_sent)
                  | (is_out & ev.bank_received);
               // new request beats a finishing one
               kill_reg <= (kill_reg & ~kill_done)
                  | cset[usb_ep_pkg::B_KILL];
               pause_reg <= (pause_reg | cset[usb_ep_pkg::B_DMAPAUSE])
                  & ~cclr[usb_ep_pkg::B_DMAPAUSE];
               // a fresh setup wins over a same-cycle set
               stall_reg <= setup_rx ? 1'b0
                  : (stall_reg | cset[usb_ep_pkg::B_STALL])
                    & ~cclr[usb_ep_pkg::B_STALL];
               if (cset[usb_ep_pkg::B_TOGGLE]) begin
                  toggle_reg <= usb_ep_pkg::TOGGLE_INIT;
               end else if (packet) begin
                  toggle_reg <= {1'b0, ev.data_pid};
               end
            end
         end

         // engine/dma commands, all registered
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctl_reg <= '0;
               irq_reg <= 1'b0;
            end else if (ce) begin
               ctl_reg.busy_bank_count <= count;
               ctl_reg.bank_commit     <= commit;
               ctl_reg.bank_release    <= release_bank;
               ctl_reg.kill_bank       <= kill_accept;
               // self-clearing: one pulse, never visible
               ctl_reg.toggle_reset  <= cset[usb_ep_pkg::B_TOGGLE];
               ctl_reg.stall_request <= stall_reg;
               // bank in flight finishes; next one not asked
               ctl_reg.dma_hold_new  <= pause_reg & irq_src;
               ctl_reg.dma_pause_now <= pause_reg & late_src;
               irq_reg <= irq_src;
            end
         end

         assign usb_ctl[e]      = ctl_reg;
         assign endpoint_irq[e] = irq_reg;

         // read-only control view, reset zero, stride four
         always_comb begin
            ctrl_word[e]                         = usb_ep_pkg::CTRL_RESET;
            ctrl_word[e][7:0]                    = en_reg;
            ctrl_word[e][usb_ep_pkg::B_BUSY]     = en_busy_reg;
            ctrl_word[e][usb_ep_pkg::B_KILL]     = kill_reg;
            ctrl_word[e][usb_ep_pkg::B_HANDOVER] = handover_reg
                                                 & ~is_ctl;
            ctrl_word[e][usb_ep_pkg::B_DMAPAUSE] = pause_reg;
            ctrl_word[e][usb_ep_pkg::B_STALL]    = stall_reg;
         end

         // status view of flags and bank state
         always_comb begin
            status_word[e]      = 32'h0000_0000;
            status_word[e][7:0] = flags_reg;
            status_word[e][usb_ep_pkg::S_TOGGLE +: 2] = toggle_reg;
            status_word[e][usb_ep_pkg::S_COUNT +: 2]  = count;
            status_word[e][usb_ep_pkg::S_BUSY]  = busy_src;
            // no room while stalled; meaningless on control
            status_word[e][usb_ep_pkg::S_RW_ALLOWED] = handover_reg
                                                & ~stall_reg & ~is_ctl;
            status_word[e][usb_ep_pkg::S_IRQ]   = irq_reg;
         end

         assign cfg_word[e] = {28'h0000000, cfg_reg};
      end
   endgenerate

endmodule

`default_nettype wire

// File: hw/usb_ep_pkg.sv
// endpoint control package: offsets, bit positions, carriers
// assumes a 12-bit apb byte address and seven endpoints

`default_nettype none

package usb_ep_pkg;

   // ----------------------------------------
   // map
   // ----------------------------------------
   localparam int          NUM_EP       = 7;
   localparam logic [11:0] OFS_CFG      = 12'h100;
   localparam logic [11:0] OFS_STATUS   = 12'h130;
   localparam logic [11:0] OFS_STA_CLR  = 12'h160;
   localparam logic [11:0] OFS_STA_SET  = 12'h190;
   localparam logic [11:0] OFS_CTRL     = 12'h1c0;
   localparam logic [11:0] OFS_CTRL_SET = 12'h1f0;
   localparam logic [11:0] OFS_CTRL_CLR = 12'h220;
   localparam logic [11:0] EP_SPAN      = 12'h01c;

   // ----------------------------------------
   // control word bits, shared by set/clear
   // ----------------------------------------
   localparam int B_BUSY     = 12;
   localparam int B_KILL     = 13;
   localparam int B_HANDOVER = 14;
   localparam int B_DMAPAUSE = 16;
   localparam int B_TOGGLE   = 18;
   localparam int B_STALL    = 19;
   localparam int NEWBANK_W  = 2;

   // status word: flags 7:0, toggle 9:8, count 11:10
   localparam int S_TOGGLE = 8;
   localparam int S_COUNT  = 10;
   localparam int S_BUSY   = 12;
   localparam int S_RW_ALLOWED  = 13;
   localparam int S_IRQ    = 14;

   // config word: type 1:0, bank number 3:2
   localparam int          C_BANKS     = 2;
   localparam logic [3:0]  CFG_RESET   = 4'h4;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   localparam logic [1:0]  TOGGLE_INIT = 2'h1;

   typedef enum logic [1:0] {
      EP_CONTROL,
      EP_IN,
      EP_OUT,
      EP_OFF
   } ep_type_e;

   // events from the packet engine, one cycle each
   typedef struct packed {
      logic data_pid;
      logic in_token;
      logic short_packet;
      logic crc_stalled;
      logic overflow;
      logic nak_in;
      logic nak_out;
      logic setup_underflow;
      logic bank_received;
      logic bank_sent;
   } usb_evt_s;

   // commands to the packet engine and dma
   typedef struct packed {
      logic [1:0] busy_bank_count;
      logic       bank_commit;
      logic       bank_release;
      logic       kill_bank;
      logic       toggle_reset;
      logic       stall_request;
      logic       dma_hold_new;
      logic       dma_pause_now;
   } usb_ctl_s;

endpackage

`default_nettype wire
